// ==== rtl/dpim_pkg.sv ====
// Shared constants and types of the digital process image mapper.
package dpim_pkg;

    // Register byte offsets on the AXI4-Lite bus.
    localparam int unsigned DPIM_ADDR_W = 8;
    localparam logic [7:0] DPIM_OFF_CTRL = 8'h00;
    localparam logic [7:0] DPIM_OFF_OUT_IMG = 8'h04;
    localparam logic [7:0] DPIM_OFF_ANA_LEN = 8'h08;
    localparam logic [7:0] DPIM_OFF_IN_IMG = 8'h0C;
    localparam logic [7:0] DPIM_OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] DPIM_OFF_IRQ_MASK = 8'h14;
    localparam logic [7:0] DPIM_OFF_LIVE = 8'h18;

    // Widths of the process images and of the fields.
    localparam int unsigned DPIM_IN_CH = 16;
    localparam int unsigned DPIM_OUT_CH = 2;
    localparam int unsigned DPIM_BYTE_W = 8;
    localparam int unsigned DPIM_MODE_W = 3;
    localparam int unsigned DPIM_ANA_W = 2;
    localparam int unsigned DPIM_IRQ_W = 5;
    localparam int unsigned DPIM_CODE_W = 2;

    // Reset values.
    localparam logic [31:0] DPIM_RST_OUT_IMG = 32'h0000_0000;
    localparam logic [2:0] DPIM_RST_MODE = 3'h0;
    localparam logic [1:0] DPIM_RST_ANA_LEN = 2'h0;
    localparam logic [4:0] DPIM_RST_IRQ = 5'h00;

    // Interrupt status bit positions.
    localparam int unsigned DPIM_IRQ_FAULT0 = 0;
    localparam int unsigned DPIM_IRQ_FAULT1 = 1;
    localparam int unsigned DPIM_IRQ_IN_CHG = 2;
    localparam int unsigned DPIM_IRQ_MANUAL = 3;
    localparam int unsigned DPIM_IRQ_FAULT_CLR = 4;

    // Two-bit fault codes.
    localparam logic [1:0] DPIM_CODE_OK = 2'h0;
    localparam logic [1:0] DPIM_CODE_OPEN = 2'h1;
    localparam logic [1:0] DPIM_CODE_SHORT = 2'h2;

    // Field positions in the live status register.
    localparam int unsigned DPIM_LIVE_OUT_LSB = 0;
    localparam int unsigned DPIM_LIVE_FLAG_LSB = 2;
    localparam int unsigned DPIM_LIVE_CODE_LSB = 4;
    localparam int unsigned DPIM_LIVE_MAN_BIT = 8;

    // AXI responses.
    localparam logic [1:0] DPIM_RESP_OKAY = 2'h0;
    localparam logic [1:0] DPIM_RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        DPIM_MODE_IN16,
        DPIM_MODE_OUT1,
        DPIM_MODE_OUT2,
        DPIM_MODE_DIAG1,
        DPIM_MODE_DIAG2
    } dpim_mode_t;

endpackage

// ==== rtl/dpim_sync.sv ====
// Two-stage synchroniser for a bus of pin levels.
`timescale 1ns/100ps
module dpim_sync #(
    parameter int unsigned W = 1
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Levels
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] meta_r;

    // The first stage feeds only the second stage.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            meta_r <= '0;
            sync_o <= '0;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end

endmodule

// ==== rtl/dpim_fault_enc.sv ====
// Per-channel fault flag and two-bit fault code encoder.
`timescale 1ns/100ps
module dpim_fault_enc
    import dpim_pkg::*;
(
    // Synchronised fault conditions per output channel
    input wire logic [DPIM_OUT_CH-1:0] open_i,
    input wire logic [DPIM_OUT_CH-1:0] short_i,
    // Encoded diagnostics
    output logic [DPIM_OUT_CH-1:0] flag_o,
    output logic [DPIM_OUT_CH*DPIM_CODE_W-1:0] code_o
);

    // A short wins over an open load because it is the condition that can damage the driver.
    function automatic logic [1:0] enc_code(input logic open_c, input logic short_c);
        logic [1:0] c;
        c = DPIM_CODE_OK;
        if (short_c) begin
            c = DPIM_CODE_SHORT;
        end else if (open_c) begin
            c = DPIM_CODE_OPEN;
        end
        return c;
    endfunction

    always_comb begin
        flag_o = '0;
        code_o = '0;
        for (int i = 0; i < DPIM_OUT_CH; i++) begin
            flag_o[i] = open_i[i] | short_i[i];
            code_o[i*DPIM_CODE_W +: DPIM_CODE_W] = enc_code(open_i[i], short_i[i]);
        end
    end

endmodule

// ==== rtl/dpim_top.sv ====
// Digital process image mapper with an AXI4-Lite register slave.
`timescale 1ns/100ps
module dpim_top (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // AXI4-Lite write address channel
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [dpim_pkg::DPIM_ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic [2:0] s_axi_awprot_i,
    // AXI4-Lite write data channel
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    // AXI4-Lite write response channel
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    output logic [1:0] s_axi_bresp_o,
    // AXI4-Lite read address channel
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    input wire logic [dpim_pkg::DPIM_ADDR_W-1:0] s_axi_araddr_i,
    input wire logic [2:0] s_axi_arprot_i,
    // AXI4-Lite read data channel
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    // Input channel pins
    input wire logic [dpim_pkg::DPIM_IN_CH-1:0] input_channel_bit_i,
    // Output channel pins, their fault sensing and the manual mode pin
    output logic [dpim_pkg::DPIM_OUT_CH-1:0] out_channel_o,
    input wire logic [dpim_pkg::DPIM_OUT_CH-1:0] fault_open_i,
    input wire logic [dpim_pkg::DPIM_OUT_CH-1:0] fault_short_i,
    input wire logic manual_mode_i,
    // Interrupt
    output logic irq_o
);

    import dpim_pkg::*;

    // Synchronised pins.
    logic [DPIM_IN_CH-1:0] in_s;
    logic [DPIM_OUT_CH-1:0] open_s;
    logic [DPIM_OUT_CH-1:0] short_s;
    logic manual_s;

    dpim_sync #(.W(DPIM_IN_CH + 2 * DPIM_OUT_CH + 1)) u_sync (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .async_i({manual_mode_i, fault_short_i, fault_open_i, input_channel_bit_i}),
        .sync_o({manual_s, short_s, open_s, in_s})
    );

    logic [DPIM_OUT_CH-1:0] flag_c;
    logic [DPIM_OUT_CH*DPIM_CODE_W-1:0] code_c;

    dpim_fault_enc u_enc (
        .open_i(open_s),
        .short_i(short_s),
        .flag_o(flag_c),
        .code_o(code_c)
    );

    // Software state.
    logic [DPIM_MODE_W-1:0] mode_r;
    logic [31:0] out_img_r;
    logic [DPIM_ANA_W-1:0] ana_len_r;
    logic [DPIM_IRQ_W-1:0] irq_stat_r;
    logic [DPIM_IRQ_W-1:0] irq_mask_r;

    // Process image state.
    logic [15:0] in_img_r;
    logic [15:0] in_img_nxt;
    logic [DPIM_OUT_CH-1:0] out_ch_nxt;
    logic [DPIM_OUT_CH-1:0] flag_r;
    logic manual_r;
    logic [DPIM_BYTE_W-1:0] dig_byte;
    dpim_mode_t mode;

    // AXI handshake state.
    logic aw_hold_r;
    logic w_hold_r;
    logic [DPIM_ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic wr_fire;
    logic ar_fire;
    logic wr_hit;
    logic [DPIM_IRQ_W-1:0] irq_ev_c;
    logic [DPIM_IRQ_W-1:0] irq_clr_c;

    assign mode = dpim_mode_t'(mode_r);
    assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid_o;
    assign ar_fire = s_axi_arvalid_i && s_axi_arready_o;

    function automatic logic addr_known(input logic [DPIM_ADDR_W-1:0] a);
        return (a == DPIM_OFF_CTRL) || (a == DPIM_OFF_OUT_IMG) || (a == DPIM_OFF_ANA_LEN) ||
               (a == DPIM_OFF_IN_IMG) || (a == DPIM_OFF_IRQ_STAT) ||
               (a == DPIM_OFF_IRQ_MASK) || (a == DPIM_OFF_LIVE);
    endfunction

    function automatic logic [7:0] strb_merge(input logic [7:0] old_b, input logic [7:0] new_b,
                                              input logic en);
        return en ? new_b : old_b;
    endfunction

    assign wr_hit = addr_known(awaddr_r);

    // Write address channel: taken once, then held until the response is accepted.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            aw_hold_r <= 1'b0;
            awaddr_r <= '0;
            s_axi_awready_o <= 1'b1;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr_i;
            s_axi_awready_o <= 1'b0;
        end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            aw_hold_r <= 1'b0;
            s_axi_awready_o <= 1'b1;
        end
    end

    // Write data channel, independent of the address so either may come first.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            w_hold_r <= 1'b0;
            wdata_r <= '0;
            wstrb_r <= '0;
            s_axi_wready_o <= 1'b1;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata_i;
            wstrb_r <= s_axi_wstrb_i;
            s_axi_wready_o <= 1'b0;
        end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            w_hold_r <= 1'b0;
            s_axi_wready_o <= 1'b1;
        end
    end

    // Write response.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= DPIM_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_hit ? DPIM_RESP_OKAY : DPIM_RESP_SLVERR;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // Control registers; only the low byte lane carries the narrow fields.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            mode_r <= DPIM_RST_MODE;
            ana_len_r <= DPIM_RST_ANA_LEN;
            irq_mask_r <= DPIM_RST_IRQ;
        end else if (wr_fire && wstrb_r[0]) begin
            if (awaddr_r == DPIM_OFF_CTRL) begin
                mode_r <= wdata_r[DPIM_MODE_W-1:0];
            end
            if (awaddr_r == DPIM_OFF_ANA_LEN) begin
                ana_len_r <= wdata_r[DPIM_ANA_W-1:0];
            end
            if (awaddr_r == DPIM_OFF_IRQ_MASK) begin
                irq_mask_r <= wdata_r[DPIM_IRQ_W-1:0];
            end
        end
    end

    // Output process image, four bytes: analog bytes first, then the digital byte.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            out_img_r <= DPIM_RST_OUT_IMG;
        end else if (wr_fire && awaddr_r == DPIM_OFF_OUT_IMG) begin
            for (int b = 0; b < 4; b++) begin
                out_img_r[b*8 +: 8] <= strb_merge(out_img_r[b*8 +: 8], wdata_r[b*8 +: 8],
                                                  wstrb_r[b]);
            end
        end
    end

    // Read channel; rdata is sampled at the address handshake so it stays stable.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            s_axi_arready_o <= 1'b1;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= '0;
            s_axi_rresp_o <= DPIM_RESP_OKAY;
        end else if (ar_fire) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rresp_o <= addr_known(s_axi_araddr_i) ? DPIM_RESP_OKAY : DPIM_RESP_SLVERR;
            case (s_axi_araddr_i)
                DPIM_OFF_CTRL: begin
                    s_axi_rdata_o <= {29'h0000_0000, mode_r};
                end
                DPIM_OFF_OUT_IMG: begin
                    s_axi_rdata_o <= out_img_r;
                end
                DPIM_OFF_ANA_LEN: begin
                    s_axi_rdata_o <= {30'h0000_0000, ana_len_r};
                end
                DPIM_OFF_IN_IMG: begin
                    s_axi_rdata_o <= {16'h0000, in_img_r};
                end
                DPIM_OFF_IRQ_STAT: begin
                    s_axi_rdata_o <= {27'h000_0000, irq_stat_r};
                end
                DPIM_OFF_IRQ_MASK: begin
                    s_axi_rdata_o <= {27'h000_0000, irq_mask_r};
                end
                DPIM_OFF_LIVE: begin
                    s_axi_rdata_o <= {23'h00_0000, manual_s, code_c, flag_c, out_channel_o};
                end
                default: begin
                    s_axi_rdata_o <= 32'h0000_0000;
                end
            endcase
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_arready_o <= 1'b1;
        end
    end

    // Digital output byte follows the analog bytes.
    always_comb begin
        dig_byte = out_img_r[ana_len_r*DPIM_BYTE_W +: DPIM_BYTE_W];
    end

    // Output channel drive per mode; bits above the used ones are never looked at.
    always_comb begin
        out_ch_nxt = '0;
        case (mode)
            DPIM_MODE_OUT1: begin
                out_ch_nxt[0] = dig_byte[0];
            end
            DPIM_MODE_OUT2: begin
                out_ch_nxt = dig_byte[DPIM_OUT_CH-1:0];
            end
            DPIM_MODE_DIAG1: begin
                out_ch_nxt = dig_byte[DPIM_OUT_CH-1:0];
            end
            DPIM_MODE_DIAG2: begin
                out_ch_nxt = dig_byte[DPIM_OUT_CH-1:0];
            end
            default: begin
                out_ch_nxt = '0;
            end
        endcase
    end

    // One control bit sets one output, through a register, one cycle later.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            out_channel_o <= '0;
        end else begin
            out_channel_o <= out_ch_nxt;
        end
    end

    // Input process image per mode; anything not assigned stays zero.
    always_comb begin
        in_img_nxt = '0;
        case (mode)
            DPIM_MODE_IN16: begin
                in_img_nxt[7:0] = in_s[7:0];
                in_img_nxt[15:8] = in_s[15:8];
            end
            DPIM_MODE_OUT1: begin
                in_img_nxt[0] = manual_s;
            end
            DPIM_MODE_DIAG1: begin
                in_img_nxt[DPIM_OUT_CH-1:0] = flag_c;
            end
            DPIM_MODE_DIAG2: begin
                in_img_nxt[DPIM_OUT_CH*DPIM_CODE_W-1:0] = code_c;
            end
            default: begin
                in_img_nxt = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            in_img_r <= '0;
        end else begin
            in_img_r <= in_img_nxt;
        end
    end

    // Previous values for event detection.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            flag_r <= '0;
            manual_r <= 1'b0;
        end else begin
            flag_r <= flag_c;
            manual_r <= manual_s;
        end
    end

    // Events and software clears of this cycle.
    always_comb begin
        irq_ev_c = '0;
        irq_clr_c = '0;
        irq_ev_c[DPIM_IRQ_FAULT0] = flag_c[0] && !flag_r[0];
        irq_ev_c[DPIM_IRQ_FAULT1] = flag_c[1] && !flag_r[1];
        irq_ev_c[DPIM_IRQ_IN_CHG] = in_img_nxt != in_img_r;
        irq_ev_c[DPIM_IRQ_MANUAL] = manual_s != manual_r;
        irq_ev_c[DPIM_IRQ_FAULT_CLR] = |(flag_r & ~flag_c);
        if (wr_fire && awaddr_r == DPIM_OFF_IRQ_STAT && wstrb_r[0]) begin
            irq_clr_c = wdata_r[DPIM_IRQ_W-1:0];
        end
    end

    // Sticky status, cleared by writing one; a new event in the clearing cycle wins.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            irq_stat_r <= DPIM_RST_IRQ;
        end else begin
            irq_stat_r <= (irq_stat_r & ~irq_clr_c) | irq_ev_c;
        end
    end

    // The interrupt is a registered level to keep the output glitch free.
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_stat_r & irq_mask_r);
        end
    end

endmodule

// ==== tb/dpim_monitor.sv ====
// Concurrent checks on the ports of the process image mapper.
`timescale 1ns/100ps
module dpim_monitor (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // Register bus
    input wire logic s_axi_awvalid_i,
    input wire logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic s_axi_wready_o,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [31:0] s_axi_rdata_o,
    // Pins
    input wire logic [dpim_pkg::DPIM_OUT_CH-1:0] out_channel_o,
    input wire logic irq_o
);
    import dpim_pkg::*;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    sequence s_wr_take;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    sequence s_wr_answer;
        !s_axi_awready_o && !s_axi_wready_o ##1 s_axi_bvalid_o;
    endsequence
    a_wr_answer: assert property (s_wr_take |=> s_wr_answer)
        else $error("write response not on time");
    a_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o
        |=> s_axi_rvalid_o && !s_axi_arready_o) else $error("read data not on time");
    a_b_stands: assert property (s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
    a_r_stands: assert property (s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("read data dropped");
    a_ready_back: assert property (s_axi_bvalid_o && s_axi_bready_i
        |=> s_axi_awready_o && s_axi_wready_o && !s_axi_bvalid_o) else $error("no new write");
    a_resp_legal: assert property (s_axi_bvalid_o
        |-> s_axi_bresp_o == DPIM_RESP_OKAY || s_axi_bresp_o == DPIM_RESP_SLVERR)
        else $error("illegal write response");
    a_rst_idle: assert property ($fell(rst_i) |-> s_axi_awready_o && s_axi_arready_o
        && !s_axi_bvalid_o && !s_axi_rvalid_o && !irq_o && out_channel_o == 2'h0)
        else $error("outputs not idle after reset");
    a_out_cause: assert property ($changed(out_channel_o) |-> $past(s_axi_bvalid_o))
        else $error("output moved without a register write");
endmodule
bind dpim_top dpim_monitor u_mon (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .s_axi_awvalid_i(s_axi_awvalid_i),
    .s_axi_awready_o(s_axi_awready_o),
    .s_axi_wvalid_i(s_axi_wvalid_i),
    .s_axi_wready_o(s_axi_wready_o),
    .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i),
    .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o),
    .s_axi_rvalid_o(s_axi_rvalid_o),
    .s_axi_rready_i(s_axi_rready_i),
    .s_axi_rdata_o(s_axi_rdata_o),
    .out_channel_o(out_channel_o),
    .irq_o(irq_o)
);

// ==== tb/dpim_load_model.sv ====
// Field side model: an output load that opens or shorts on command.
`timescale 1ns/100ps
module dpim_load_model (
    // Clock
    input wire logic sys_clk_i,
    // Requested load faults per channel
    input wire logic [dpim_pkg::DPIM_OUT_CH-1:0] open_cmd_i,
    input wire logic [dpim_pkg::DPIM_OUT_CH-1:0] short_cmd_i,
    // Fault sense lines towards the block
    output logic [dpim_pkg::DPIM_OUT_CH-1:0] fault_open_o,
    output logic [dpim_pkg::DPIM_OUT_CH-1:0] fault_short_o
);
    import dpim_pkg::*;
    // Sense lines move on the clock, so the block never sees a glitch mid-cycle.
    always_ff @(posedge sys_clk_i) begin
        fault_open_o <= open_cmd_i;
        fault_short_o <= short_cmd_i;
    end
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the process image mapper.
`timescale 1ns/100ps
module tb_top;
    import dpim_pkg::*;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic awv = 1'h0, wv = 1'h0, bry = 1'h0, arv = 1'h0, rry = 1'h0, man = 1'h0;
    logic [7:0] awa = 8'h0, ara = 8'h0;
    logic [31:0] wd = 32'h0, rdata, d;
    logic [15:0] pins = 16'h0;
    logic [1:0] ocmd = 2'h0, scmd = 2'h0, fo, fs, outc, bresp, rresp, o, s;
    logic awr, wrdy, bv, arr, rv, irq;
    logic [3:0] cd;
    logic [1:0] qb[$];
    logic [33:0] qr[$];
    int err_count = 0;
    int n_tests = 0;

    always #10 clk = ~clk;

    dpim_top dut (.sys_clk_i(clk), .rst_i(rst),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
        .s_axi_awprot_i(3'h0), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
        .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(bry), .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_arprot_i(3'h0),
        .s_axi_rvalid_o(rv), .s_axi_rready_i(rry), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .input_channel_bit_i(pins), .out_channel_o(outc),
        .fault_open_i(fo), .fault_short_i(fs), .manual_mode_i(man), .irq_o(irq));

    dpim_load_model u_load (.sys_clk_i(clk), .open_cmd_i(ocmd), .short_cmd_i(scmd),
        .fault_open_o(fo), .fault_short_o(fs));

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up();
        if (err_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Results are compared as they appear; each access queued what it expects.
    always @(posedge clk) begin
        if (bv && bry) chk(34'(bresp), 34'(qb.pop_front()));
        if (rv && rry) chk({rresp, rdata}, qr.pop_front());
    end

    // A late bready or rready makes the answer wait, so it must stand.
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
        int n;
        int w;
        n = 0;
        w = $urandom_range(3);
        qb.push_back(r);
        awv <= 1'h1;
        wv <= 1'h1;
        awa <= a;
        wd <= v;
        bry <= 1'(w == 0);
        do begin
            @(posedge clk);
            if (awr) awv <= 1'h0;
            if (wrdy) wv <= 1'h0;
            n++;
            if (n == w) bry <= 1'h1;
        end while (!(bv && bry) && n < 50);
        bry <= 1'h0;
        @(posedge clk);
        if (n >= 50) begin
            err_count++;
            wrap_up();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
        int n;
        int w;
        n = 0;
        w = $urandom_range(3);
        qr.push_back({r, v});
        arv <= 1'h1;
        ara <= a;
        rry <= 1'(w == 0);
        do begin
            @(posedge clk);
            if (arr) arv <= 1'h0;
            n++;
            if (n == w) rry <= 1'h1;
        end while (!(rv && rry) && n < 50);
        rry <= 1'h0;
        @(posedge clk);
        if (n >= 50) begin
            err_count++;
            wrap_up();
        end
    endtask

    task automatic settle(input int c);
        // Read at the edge, outputs still show what stood through the last cycle.
        repeat (c) @(posedge clk);
    endtask

    function automatic logic [1:0] code(input logic op, input logic sh);
        return sh ? DPIM_CODE_SHORT : (op ? DPIM_CODE_OPEN : DPIM_CODE_OK);
    endfunction

    initial begin
        void'($urandom(74924));
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        rd(DPIM_OFF_CTRL, 32'h0, DPIM_RESP_OKAY);
        rd(DPIM_OFF_IRQ_MASK, 32'h0, DPIM_RESP_OKAY);
        rd(8'h1C, 32'h0, DPIM_RESP_SLVERR);
        wr(8'h1C, 32'hFFFF_FFFF, DPIM_RESP_SLVERR);
        for (int i = 0; i < 4; i++) begin
            d = $urandom;
            pins <= d[15:0];
            settle(5);
            rd(DPIM_OFF_IN_IMG, {16'h0, d[15:0]}, DPIM_RESP_OKAY);
        end
        // Mode 1 drives one channel, mode 2 both; the analog length moves the byte.
        for (int m = 1; m <= 2; m++) begin
            wr(DPIM_OFF_CTRL, 32'(m), DPIM_RESP_OKAY);
            for (int l = 0; l < 4; l++) begin
                d = $urandom;
                man <= d[31];
                wr(DPIM_OFF_ANA_LEN, 32'(l), DPIM_RESP_OKAY);
                wr(DPIM_OFF_OUT_IMG, d, DPIM_RESP_OKAY);
                settle(4);
                chk(34'(outc), 34'(m == 1 ? {1'h0, d[8*l]} : d[8*l+:2]));
                rd(DPIM_OFF_IN_IMG, m == 1 ? 32'(d[31]) : 32'h0, DPIM_RESP_OKAY);
            end
        end
        man <= 1'h0;
        wr(DPIM_OFF_OUT_IMG, 32'h0, DPIM_RESP_OKAY);
        for (int k = 0; k < 16; k++) begin
            o = 2'(k);
            s = 2'(k >> 2);
            ocmd <= o;
            scmd <= s;
            cd = {code(o[1], s[1]), code(o[0], s[0])};
            // The analog length is still three, so byte 3 drives the outputs.
            d = $urandom;
            wr(DPIM_OFF_OUT_IMG, d, DPIM_RESP_OKAY);
            settle(6);
            wr(DPIM_OFF_CTRL, 32'(DPIM_MODE_DIAG1), DPIM_RESP_OKAY);
            rd(DPIM_OFF_IN_IMG, 32'(o | s), DPIM_RESP_OKAY);
            chk(34'(outc), 34'(d[25:24]));
            wr(DPIM_OFF_CTRL, 32'(DPIM_MODE_DIAG2), DPIM_RESP_OKAY);
            rd(DPIM_OFF_IN_IMG, 32'(cd), DPIM_RESP_OKAY);
            rd(DPIM_OFF_LIVE, 32'({cd, o | s, d[25:24]}), DPIM_RESP_OKAY);
        end
        // Undefined modes switch every output off and clear the input image.
        wr(DPIM_OFF_CTRL, 32'(5 + $urandom_range(2)), DPIM_RESP_OKAY);
        settle(4);
        chk(34'(outc), 34'h0);
        rd(DPIM_OFF_IN_IMG, 32'h0, DPIM_RESP_OKAY);
        ocmd <= 2'h0;
        scmd <= 2'h0;
        settle(6);
        wr(DPIM_OFF_IRQ_STAT, 32'h1F, DPIM_RESP_OKAY);
        ocmd <= 2'h1;
        settle(8);
        chk(34'(irq), 34'h0);
        wr(DPIM_OFF_IRQ_MASK, 32'h01, DPIM_RESP_OKAY);
        settle(4);
        chk(34'(irq), 34'h1);
        wr(DPIM_OFF_IRQ_STAT, 32'h01, DPIM_RESP_OKAY);
        settle(4);
        chk(34'(irq), 34'h0);
        wr(DPIM_OFF_IRQ_MASK, 32'h10, DPIM_RESP_OKAY);
        ocmd <= 2'h0;
        settle(8);
        chk(34'(irq), 34'h1);
        wrap_up();
    end
endmodule
